// ### core/offset_null_sequencer.sv
// divider, sequencer and decision latch of the offset nulling device
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// R1: sample clock is divided by 1, 4, 16, 128 or 1024.
// R2: power-up or reset forces divide-by-one, the fastest sample rate.
// R3: first change of the latched decision switches to the programmed ratio.
// R4: reset during operation returns to fastest rate until next first toggle.
// R5: each divider output pulse starts one full sample-and-correct pass.
// R6: decision is latched, held until next, and shown on the result pin.
// R7: a sample away from reference gives one step opposing the error.
// R8: one step per sample cycle, continuing indefinitely after null.
// R9: without external clock an internal 100 kHz oscillator clocks the device.
// R10: an external clock may replace the internal one, at most 100 kHz.
// R11: holding the clock input stops divider and sequencer; resumes on release. Code: osc_hold_i gates only the internal oscillator, not external edges.
// R12: each comparator stage is zeroed in turn, first to last, before deciding.
// R13: each latched decision makes exactly one fixed step signed by the latch.
// R14: outside system should pick a sample period above amplifier settling time.
// R15: result output updates at most once per sample period.
// R16: reset pin is active low and selects the fastest sample rate.
// R17: rate code {high,low} selects divide-by 4, 16, 128, 1024 ascending.
module offset_null_sequencer
(
	// system
	input wire logic clk_i,
	input wire logic reset_i,
	// device pins, asynchronous to clk_i
	input wire logic reset_n_i,
	input wire logic rate_select_low_i,
	input wire logic rate_select_high_i,
	input wire logic ext_clk_i,
	input wire logic ext_clk_select_i,
	input wire logic osc_hold_i,
	input wire logic comparator_above_i,
	// comparator result, open drain
	output logic comparator_result_out_o,
	output logic comparator_result_out_oe_o,
	// comparator stage and latch control
	output logic [offset_null_pkg::STAGES-1:0] stage_zero_o,
	output logic latch_enable_o,
	// integrator step
	output offset_null_pkg::step_t correction_step_o
);
	import offset_null_pkg::*;

	// pin synchronisers
	logic [SY_W-1:0] sy1_q;
	logic [SY_W-1:0] sy2_q;
	logic [SY_W-1:0] pins;
	logic ext_prev_q;
	logic ext_prev_d;

	assign pins = {comparator_above_i, osc_hold_i, ext_clk_select_i, ext_clk_i,
		rate_select_high_i, rate_select_low_i, reset_n_i};
	assign ext_prev_d = sy2_q[SY_EXT_CLK];

	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			sy1_q <= SY_RESET_VAL;
			sy2_q <= SY_RESET_VAL;
			ext_prev_q <= 1'b0;
		end
		else
		begin
			sy1_q <= pins;
			sy2_q <= sy1_q;
			ext_prev_q <= ext_prev_d;
		end
	end

	logic dev_rst;
	logic osc_hold;
	logic ext_sel;
	assign dev_rst = ~sy2_q[SY_RESET_N]; // R16
	assign osc_hold = sy2_q[SY_OSC_HOLD];
	assign ext_sel = sy2_q[SY_EXT_SEL];

	// clock source: internal oscillator or external clock edges
	logic [OSC_CNT_W-1:0] osc_cnt_q;
	logic [OSC_CNT_W-1:0] osc_cnt_d;
	logic osc_tick;
	logic clk_tick;

	always_comb
	begin
		osc_cnt_d = osc_cnt_q;
		osc_tick = 1'b0;
		if (!osc_hold) // R11
		begin
			if (osc_cnt_q == OSC_LAST) // R9
			begin
				osc_cnt_d = '0;
				osc_tick = 1'b1;
			end
			else
			begin
				osc_cnt_d = osc_cnt_q + 1'b1;
			end
		end
		// external rate is trusted to stay at or below the oscillator rate
		clk_tick = ext_sel ? (sy2_q[SY_EXT_CLK] & ~ext_prev_q) : osc_tick; // R10
	end

	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			osc_cnt_q <= '0;
		else
			osc_cnt_q <= osc_cnt_d;
	end

	// rate divider with two-speed gear
	logic [DIV_W-1:0] div_cnt_q;
	logic [DIV_W-1:0] div_cnt_d;
	logic [DIV_W-1:0] ratio;
	logic [DIV_W-1:0] prog_ratio;
	logic div_pulse;
	logic fast_q;
	logic fast_d;
	logic seen_q;
	logic seen_d;

	seq_state_t state_q;
	seq_state_t state_d;
	logic decision_q;
	logic decision_d;
	logic latch_q;
	logic latch_d;

	always_comb
	begin
		case ({sy2_q[SY_RATE_HIGH], sy2_q[SY_RATE_LOW]}) // R17
			RATE_CODE_4: prog_ratio = DIV_BY_4;
			RATE_CODE_16: prog_ratio = DIV_BY_16;
			RATE_CODE_128: prog_ratio = DIV_BY_128;
			default: prog_ratio = DIV_BY_1024;
		endcase
		ratio = fast_q ? DIV_BY_1 : prog_ratio; // R1
		div_cnt_d = div_cnt_q;
		div_pulse = 1'b0;
		if (clk_tick)
		begin
			// compare with >= so a ratio drop mid-count cannot overrun
			if (div_cnt_q >= ratio - 1'b1)
			begin
				div_cnt_d = '0;
				div_pulse = 1'b1;
			end
			else
			begin
				div_cnt_d = div_cnt_q + 1'b1;
			end
		end
		fast_d = fast_q;
		seen_d = seen_q;
		if (state_q == S_LATCH)
		begin
			seen_d = 1'b1;
			if (seen_q && decision_q != latch_q)
				fast_d = 1'b0; // R3
		end
		if (dev_rst)
		begin
			fast_d = 1'b1; // R2 R4
			seen_d = 1'b0;
			div_cnt_d = '0;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			div_cnt_q <= '0;
			fast_q <= 1'b1;
			seen_q <= 1'b0;
		end
		else
		begin
			div_cnt_q <= div_cnt_d;
			fast_q <= fast_d;
			seen_q <= seen_d;
		end
	end

	// sequencer: zero stages, decide, latch, step
	logic [1:0] stage_q;
	logic [1:0] stage_d;
	logic [STAGES-1:0] stage_zero_d;
	logic latch_en_d;
	step_t step_d;
	logic res_oe_d;

	always_comb
	begin
		state_d = state_q;
		stage_d = stage_q;
		decision_d = decision_q;
		latch_d = latch_q;
		step_d = STEP_NONE;
		latch_en_d = 1'b0;
		case (state_q)
			S_IDLE:
			begin
				// a pulse during a pass is dropped: one result per period
				if (div_pulse && !dev_rst) // R5 R15
				begin
					state_d = S_ZERO;
					stage_d = STAGE_FIRST;
				end
			end
			S_ZERO:
			begin
				if (stage_q == STAGE_LAST) // R12
					state_d = S_DECIDE;
				else
					stage_d = stage_q + 1'b1;
			end
			S_DECIDE:
			begin
				decision_d = sy2_q[SY_CMP];
				state_d = S_LATCH;
			end
			S_LATCH:
			begin
				latch_d = decision_q; // R6
				latch_en_d = 1'b1;
				state_d = S_STEP;
			end
			S_STEP:
			begin
				step_d.down = latch_q; // R7 R13
				step_d.up = ~latch_q; // R7 R13
				state_d = S_IDLE; // R8
			end
			default:
			begin
				state_d = S_IDLE;
			end
		endcase
		stage_zero_d = (state_d == S_ZERO) ? (STAGE_ONE << stage_d) : '0; // R12
		res_oe_d = ~latch_d; // R6
	end

	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			state_q <= S_IDLE;
			stage_q <= STAGE_FIRST;
			decision_q <= 1'b0;
			latch_q <= 1'b0;
			stage_zero_o <= '0;
			latch_enable_o <= 1'b0;
			correction_step_o <= STEP_NONE;
			comparator_result_out_o <= 1'b0;
			comparator_result_out_oe_o <= 1'b1;
		end
		else
		begin
			state_q <= state_d;
			stage_q <= stage_d;
			decision_q <= decision_d;
			latch_q <= latch_d;
			stage_zero_o <= stage_zero_d;
			latch_enable_o <= latch_en_d;
			correction_step_o <= step_d;
			comparator_result_out_o <= 1'b0;
			comparator_result_out_oe_o <= res_oe_d;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	fast_on_reset_a: assert property (dev_rst |=> fast_q && ratio == DIV_BY_1) // R2
		else $error("divider not forced to divide-by-one under reset");
	rate_table_a: assert property (!fast_q |-> ratio == prog_ratio && ratio != DIV_BY_1) // R17
		else $error("programmed ratio not in use after gear shift");
	gear_shift_a: assert property (fast_q && !dev_rst && state_q == S_LATCH && seen_q
		&& decision_q != latch_q |=> !fast_q) // R3
		else $error("first toggle did not leave divide-by-one");
	pass_start_a: assert property (div_pulse && !dev_rst && state_q == S_IDLE
		|=> state_q == S_ZERO ##4 state_q == S_DECIDE) // R5
		else $error("divider pulse did not start a pass");
	zero_order_a: assert property (state_q == S_ZERO && stage_q == STAGE_FIRST
		|-> stage_zero_o == 4'h1 ##1 stage_zero_o == 4'h2 ##1 stage_zero_o == 4'h4
		##1 stage_zero_o == 4'h8 ##1 stage_zero_o == 4'h0) // R12
		else $error("stages not zeroed first to last");
	latch_show_a: assert property (state_q == S_LATCH |=> latch_enable_o
		&& latch_q == $past(decision_q) && comparator_result_out_oe_o == !$past(decision_q)) // R6
		else $error("latched decision not shown on result pin");
	step_sign_a: assert property (state_q == S_STEP |=> correction_step_o.down == latch_q
		&& correction_step_o.up == !latch_q ##1 correction_step_o == STEP_NONE) // R13
		else $error("step missing, doubled or of wrong sign");
	result_rate_a: assert property ($changed(comparator_result_out_oe_o)
		|-> $past(state_q) == S_LATCH) // R15
		else $error("result pin changed outside the latch phase");
	osc_halt_a: assert property (osc_hold && !ext_sel |-> !clk_tick && !div_pulse) // R11
		else $error("activity while the clock is held");
	osc_period_a: assert property (osc_tick |-> osc_cnt_q == OSC_LAST && !osc_hold) // R9
		else $error("oscillator tick off its period");

	gear_shift_c: cover property (fast_q ##1 !fast_q);
	step_up_c: cover property (correction_step_o.up);
	step_down_c: cover property (correction_step_o.down);
	ext_pulse_c: cover property (ext_sel && div_pulse);
endmodule

`default_nettype wire

// ### pkg/offset_null_pkg.sv
// shared constants and types for the offset nulling sequencer
package offset_null_pkg;
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int OSC_FREQ_HZ = 100000;
	localparam int OSC_PERIOD_NS = 1000000000 / OSC_FREQ_HZ;
	localparam int OSC_CYCLES = OSC_PERIOD_NS / CLK_PERIOD_NS;
	localparam int OSC_CNT_W = 10;
	localparam logic [OSC_CNT_W-1:0] OSC_LAST = OSC_CNT_W'(OSC_CYCLES - 1);

	// divider ratios
	localparam int DIV_W = 11;
	localparam logic [DIV_W-1:0] DIV_BY_1 = 11'h001;
	localparam logic [DIV_W-1:0] DIV_BY_4 = 11'h004;
	localparam logic [DIV_W-1:0] DIV_BY_16 = 11'h010;
	localparam logic [DIV_W-1:0] DIV_BY_128 = 11'h080;
	localparam logic [DIV_W-1:0] DIV_BY_1024 = 11'h400;

	// rate-select codes {high, low}
	localparam logic [1:0] RATE_CODE_4 = 2'h0;
	localparam logic [1:0] RATE_CODE_16 = 2'h1;
	localparam logic [1:0] RATE_CODE_128 = 2'h2;

	// comparator stages
	localparam int STAGES = 4;
	localparam logic [1:0] STAGE_FIRST = 2'h0;
	localparam logic [1:0] STAGE_LAST = 2'h3;
	localparam logic [STAGES-1:0] STAGE_ONE = 4'h1;

	// synchroniser slot positions
	localparam int SY_RESET_N = 0;
	localparam int SY_RATE_LOW = 1;
	localparam int SY_RATE_HIGH = 2;
	localparam int SY_EXT_CLK = 3;
	localparam int SY_EXT_SEL = 4;
	localparam int SY_OSC_HOLD = 5;
	localparam int SY_CMP = 6;
	localparam int SY_W = 7;
	localparam logic [SY_W-1:0] SY_RESET_VAL = 7'h00;

	typedef enum logic [4:0] {
		S_IDLE = 5'h01,
		S_ZERO = 5'h02,
		S_DECIDE = 5'h04,
		S_LATCH = 5'h08,
		S_STEP = 5'h10
	} seq_state_t;

	// one correction step towards the integrator
	typedef struct packed {
		logic up;
		logic down;
	} step_t;

	localparam step_t STEP_NONE = 2'h0;
endpackage

// ### test/offset_null_sequencer_test.sv
// self-checking bench for the offset nulling sequencer
`timescale 1ns/1ps
`default_nettype none
module offset_null_sequencer_test;
	import offset_null_pkg::*;
	logic clk_i, reset_i, rst_n, rsl, rsh, xclk, xsel, hold, above;
	logic dat, oe, len;
	logic [STAGES-1:0] sz, sz_exp;
	step_t step;
	logic signed [15:0] kick;
	logic [7:0] lfsr;
	logic [1:0] sdue;
	logic dec, prev;
	int miscompares, total_checks, etot, elast, xdiv, n, k, cnt;
	logic [15:0] exp_q[$];
	logic [15:0] ratio[4] = '{16'h0004, 16'h0010, 16'h0080, 16'h0400};

	offset_null_sequencer uut (.clk_i(clk_i), .reset_i(reset_i), .reset_n_i(rst_n),
		.rate_select_low_i(rsl), .rate_select_high_i(rsh), .ext_clk_i(xclk),
		.ext_clk_select_i(xsel), .osc_hold_i(hold), .comparator_above_i(above),
		.comparator_result_out_o(dat), .comparator_result_out_oe_o(oe),
		.stage_zero_o(sz), .latch_enable_o(len), .correction_step_o(step));
	summing_node_model node (.clk_i(clk_i), .reset_i(reset_i), .step_i(step),
		.kick_i(kick), .above_o(above));

	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	task automatic check(input logic [15:0] got, input logic [15:0] want);
		total_checks++;
		if (got !== want)
		begin
			miscompares++;
			$display("[ERR] %0t got %h want %h", $time, got, want);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// bounded wait for the next decision latch
	task automatic wait_latch(input int lim);
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end while (len !== 1'b1 && n < lim);
		if (len !== 1'b1)
		begin
			miscompares++;
			conclude();
		end
	endtask

	// 8-bit maximal-length shift register, seeded with 43 below
	function automatic logic [7:0] lfsr_step(input logic [7:0] s);
		lfsr_step = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic bump(input logic signed [15:0] v);
		kick <= v;
		@(posedge clk_i);
		kick <= 16'sh0000;
	endtask

	// external sample clock, 20 system cycles a period
	// time-compressed to keep the run short: the divider only counts its edges
	always @(posedge clk_i)
	begin
		xdiv <= (xdiv == 9) ? 0 : xdiv + 1;
		if (xdiv == 9)
		begin
			xclk <= ~xclk;
			if (!xclk)
				etot <= etot + 1;
		end
	end

	// result watcher: oldest note is compared at each latch
	always @(posedge clk_i)
	begin
		sdue <= {sdue[0], len === 1'b1};
		if (sz !== 4'h0)
		begin
			check({12'h0, sz}, {12'h0, sz_exp});
			sz_exp <= {sz_exp[2:0], sz_exp[3]};
		end
		if (len === 1'b1)
		begin
			check({15'h0, oe}, {15'h0, !above});
			check({15'h0, dat}, 16'h0000);
			dec <= above;
			if (exp_q.size() > 0)
				check(16'(etot - elast), exp_q.pop_front());
			elast <= etot;
		end
		if (sdue[0])
			check({14'h0, step}, dec ? 16'h0001 : 16'h0002);
		if (sdue[1])
			check({14'h0, step}, 16'h0000);
	end

	initial
	begin
		reset_i = 1'b1;
		{rst_n, rsl, rsh, xclk, xsel, hold, kick, sdue, dec} = '0;
		{miscompares, total_checks, etot, elast, xdiv} = '0;
		sz_exp = 4'h1;
		lfsr = 8'h2b;
		repeat (4) @(posedge clk_i);
		reset_i <= 1'b0;
		rst_n <= 1'b1;
		bump(16'sd4);
		wait_latch(3000);
		wait_latch(2000);
		check(16'(n), 16'(OSC_CYCLES));
		hold <= 1'b1;
		cnt = 0;
		repeat (3000)
		begin
			@(posedge clk_i);
			cnt += (len === 1'b1);
		end
		check(16'(cnt), 16'h0000);
		hold <= 1'b0;
		wait_latch(1100);
		xsel <= 1'b1;
		for (int c = 0; c < 4; c++)
		begin
			{rsh, rsl} <= 2'(c);
			rst_n <= 1'b0;
			repeat (4) @(posedge clk_i);
			rst_n <= 1'b1;
			// node pushed far off so at least eight decisions agree before the first toggle
			lfsr = lfsr_step(lfsr);
			bump(16'sd8 + 16'(lfsr[1:0]));
			wait_latch(200);
			wait_latch(200);
			// step off the latch edge so the watcher cannot take this note early
			@(posedge clk_i);
			exp_q.push_back(16'h0001);
			exp_q.push_back(16'h0001);
			prev = oe;
			k = 0;
			do
			begin
				wait_latch(100);
				k++;
			end while (oe === prev && k < 12);
			wait_latch(25000);
			@(posedge clk_i);
			exp_q.push_back(ratio[c]);
			wait_latch(25000);
			@(posedge clk_i);
			check(16'(exp_q.size()), 16'h0000);
		end
		conclude();
	end
endmodule
`default_nettype wire

// ### test/summing_node_model.sv
// integrator and summing node seen by the sequencer
`timescale 1ns/1ps
`default_nettype none
module summing_node_model
(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire offset_null_pkg::step_t step_i,
	input wire logic signed [15:0] kick_i,
	output logic above_o
);
	import offset_null_pkg::*;
	logic signed [15:0] lvl_q;
	// one unit per step; kick stands in for a sudden offset change
	// settles within one clock, far inside any sample period
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			lvl_q <= 16'sh0000;
		else
			lvl_q <= lvl_q + kick_i + {15'h0, step_i.up} - {15'h0, step_i.down};
	end
	assign above_o = (lvl_q > 16'sh0000);
endmodule
`default_nettype wire
